/* src/adcs_conv_if.sv */
// carrier between register side and successive-approximation core
`timescale 1ns/1ps
interface adcs_conv_if;
  import adcs_pkg::*;
  logic       tick;    // one conversion clock period elapsed
  logic       pwr;     // converter powered
  logic       start;   // begin a conversion, one cycle
  logic       abort;   // abandon the conversion, one cycle
  logic       cmp;     // synchronised comparator, input above trial
  logic       ready;   // idle; acquiring only when powered
  logic       busy;    // holding or resolving
  logic       done;    // result valid, one cycle
  adcs_byte_t result;  // finished code
  adcs_byte_t dac;     // trial code to the analog side
  logic       sample;  // sample-and-hold tracking the input
  modport core (input tick, pwr, start, abort, cmp,
                output ready, busy, done, result, dac, sample);
  modport ctl  (output tick, pwr, start, abort, cmp,
                input ready, busy, done, result, dac, sample);
endinterface : adcs_conv_if

/* src/adcs_defines.svh */
// constant definitions for the converter control sequencer
`ifndef ADCS_DEFINES_SVH
`define ADCS_DEFINES_SVH
// ==========================================
// register byte offsets
`define ADCS_AW         5
`define ADCS_OFF_CTRL   5'h00
`define ADCS_OFF_RESULT 5'h04
`define ADCS_OFF_PCFG   5'h08
`define ADCS_OFF_STAT   5'h0c
`define ADCS_OFF_MASK   5'h10
// ==========================================
// converter_control_main fields
`define ADCS_CS_HI   7
`define ADCS_CS_LO   6
`define ADCS_CHS_HI  4
`define ADCS_CHS_LO  3
`define ADCS_GO      2
`define ADCS_FLAG    1
`define ADCS_PWR     0
`define ADCS_CTRL_RMASK 8'hdf
// conversion clock codes
`define ADCS_CS_DIV2  2'h0
`define ADCS_CS_DIV8  2'h1
`define ADCS_CS_DIV32 2'h2
`define ADCS_CS_RC    2'h3
// last divider count for each divided code
`define ADCS_DIV2_LAST  5'h01
`define ADCS_DIV8_LAST  5'h07
`define ADCS_DIV32_LAST 5'h1f
// ==========================================
// port_analog_config_reg fields
`define ADCS_ANA_HI   3
`define ADCS_ANA_LO   0
`define ADCS_REF_EXT  4
`define ADCS_PCFG_RMASK 8'h1f
// ==========================================
// interrupt status bits
`define ADCS_IRQ_W     2
`define ADCS_IRQ_DONE  0
`define ADCS_IRQ_ABORT 1
// ==========================================
// sequencer constants
// the first tick after an abort may cut a period short, so the wait ends on
// the third tick to cover two whole conversion periods
`define ADCS_ABORT_LAST 2'h2
`define ADCS_SAR_MSB    3'h7
`define ADCS_TRIAL_MSB  8'h80
`define ADCS_RST8       8'h00
`endif

/* src/adcs_pkg.sv */
// shared types for the converter control sequencer
package adcs_pkg;
  // ==========================================
  // sequencer states
  typedef enum logic [1:0] {
    ADCS_IDLE,
    ADCS_HOLD,
    ADCS_BITS,
    ADCS_ABWAIT
  } adcs_state_e;
  typedef logic [7:0] adcs_byte_t;  // one converter byte
endpackage : adcs_pkg

/* src/adcs_sar_core.sv */
// successive-approximation sequencer with abort recovery
`timescale 1ns/1ps
`include "adcs_defines.svh"
module adcs_sar_core
  import adcs_pkg::*;
(
  input  wire logic clk,
  input  wire logic sys_rst,
  adcs_conv_if.core cif
);
  // ==========================================
  // state
  adcs_state_e state_ff, nxt_state;  // sequencer state
  logic [2:0]  idx_ff, nxt_idx;      // bit under trial
  logic        ph_ff, nxt_ph;        // settle phase, then decide phase
  adcs_byte_t  work_ff, nxt_work;    // decided bits plus trial bit
  adcs_byte_t  res_ff, nxt_res;      // last finished code
  logic [1:0]  wt_ff, nxt_wt;        // abort wait periods
  logic        done_ff, nxt_done;    // completion pulse
  logic        smp_ff, nxt_smp;      // sample switch closed

  assign cif.ready  = (state_ff == ADCS_IDLE);
  assign cif.busy   = (state_ff == ADCS_HOLD) || (state_ff == ADCS_BITS);
  assign cif.done   = done_ff;
  assign cif.result = res_ff;
  assign cif.dac    = work_ff;
  assign cif.sample = smp_ff;

  // next state: each bit spends two periods so the trial level and the
  // synchronised comparator settle even at the fastest clock
  always_comb begin
    nxt_state = state_ff;
    nxt_idx   = idx_ff;
    nxt_ph    = ph_ff;
    nxt_work  = work_ff;
    nxt_res   = res_ff;
    nxt_wt    = wt_ff;
    nxt_done  = 1'b0;
    case (state_ff)
      ADCS_IDLE: begin
        if (cif.start) begin
          nxt_state = ADCS_HOLD;
        end
      end
      ADCS_HOLD: begin
        if (cif.abort) begin
          nxt_state = ADCS_ABWAIT;
          nxt_wt    = 2'h0;
        end else if (cif.tick) begin
          nxt_state = ADCS_BITS;
          nxt_work  = `ADCS_TRIAL_MSB;
          nxt_idx   = `ADCS_SAR_MSB;
          nxt_ph    = 1'b0;
        end
      end
      ADCS_BITS: begin
        if (cif.abort) begin
          nxt_state = ADCS_ABWAIT;
          nxt_wt    = 2'h0;
        end else if (cif.tick) begin
          nxt_ph = ~ph_ff;
          if (ph_ff) begin
            if (!cif.cmp) begin
              nxt_work[idx_ff] = 1'b0;
            end
            if (idx_ff == 3'h0) begin
              nxt_res   = nxt_work;
              nxt_done  = 1'b1;
              nxt_state = ADCS_IDLE;
            end else begin
              nxt_work[3'(idx_ff - 3'h1)] = 1'b1;
              nxt_idx = 3'(idx_ff - 3'h1);
            end
          end
        end
      end
      ADCS_ABWAIT: begin
        if (cif.tick) begin
          if (wt_ff == `ADCS_ABORT_LAST) begin
            nxt_state = ADCS_IDLE;
          end else begin
            nxt_wt = 2'(wt_ff + 2'h1);
          end
        end
      end
      default: nxt_state = ADCS_IDLE;
    endcase
    nxt_smp = cif.pwr && (nxt_state == ADCS_IDLE);
  end

  // registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= ADCS_IDLE;
      idx_ff   <= 3'h0;
      ph_ff    <= 1'b0;
      work_ff  <= `ADCS_RST8;
      res_ff   <= `ADCS_RST8;
      wt_ff    <= 2'h0;
      done_ff  <= 1'b0;
      smp_ff   <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      idx_ff   <= nxt_idx;
      ph_ff    <= nxt_ph;
      work_ff  <= nxt_work;
      res_ff   <= nxt_res;
      wt_ff    <= nxt_wt;
      done_ff  <= nxt_done;
      smp_ff   <= nxt_smp;
    end
  end

  // ==========================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_last_bit;
    (state_ff == ADCS_BITS) && cif.tick && ph_ff && (idx_ff == 3'h0) && !cif.abort
      |=> done_ff && (state_ff == ADCS_IDLE);
  endproperty
  a_last_bit: assert property (p_last_bit) else $error("last bit did not finish");
  property p_abort_wait;
    cif.busy && cif.abort |=> (state_ff == ADCS_ABWAIT) && !done_ff;
  endproperty
  a_abort_wait: assert property (p_abort_wait) else $error("abort not taken");
endmodule : adcs_sar_core

/* src/adcs_top.sv */
// converter control sequencer: register slave, conversion clock, interrupt
// Behaviour
// - one of four channels feeds sample-hold
// - each conversion yields unsigned 8-bit code
// - held sample resolved by successive approximation
// - reference is supply or external reference pin
// - conversions complete while device sleeps only on the rc clock; divided codes stop
// - result, main control and port config registers
// - pins analog or digital, pin three reference
// - completion sets flag and clears start bit
// - clearing start aborts, result keeps old value
// - after abort wait two periods, reacquire
`timescale 1ns/1ps
`include "adcs_defines.svh"
module adcs_top
  import adcs_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic [`ADCS_AW-1:0] avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [31:0]        avs_writedata,
  input  wire logic [3:0]         avs_byteenable,
  output logic      [31:0]        avs_readdata,
  output logic                    avs_waitrequest,
  output logic                    irq,
  input  wire logic               sleep_mode,
  input  wire logic               rc_clk_pin,
  input  wire logic               cmp_pin,
  output logic                    ana_power_en,
  output logic      [1:0]         ana_chan_sel,
  output logic                    ana_ref_ext,
  output logic                    sh_sample,
  output logic      [7:0]         dac_code,
  output logic      [3:0]         pin_analog_en
);
  // ==========================================
  // register hit decode, shared by reads and writes
  function automatic logic reg_hit(input logic [`ADCS_AW-1:0] a,
                                   input logic [`ADCS_AW-1:0] off);
    reg_hit = (a == off);
  endfunction : reg_hit

  adcs_conv_if cif ();  // link to the sequencer core

  // ==========================================
  // state
  logic       wait_ff, nxt_wait;          // waitrequest, high when idle
  logic [31:0] rdata_ff, nxt_rdata;       // read data
  logic [1:0] cs_ff, nxt_cs;              // conv_clock_select
  logic [1:0] chs_ff, nxt_chs;            // input_channel_select
  logic       go_ff, nxt_go;              // start/status bit
  logic       flag_ff, nxt_flag;          // conv_complete_flag
  logic       pwr_ff, nxt_pwr;            // converter_power_bit
  adcs_byte_t res_ff, nxt_res;            // conversion_result_reg
  adcs_byte_t pcfg_ff, nxt_pcfg;          // port_analog_config_reg
  logic [`ADCS_IRQ_W-1:0] stat_ff, nxt_stat;  // sticky events
  logic [`ADCS_IRQ_W-1:0] mask_ff, nxt_mask;  // interrupt enables
  logic [`ADCS_IRQ_W-1:0] ev;             // events this cycle
  logic       irq_ff, nxt_irq;            // interrupt level
  logic       start_ff, nxt_start;        // start pulse to core
  logic       abort_ff, nxt_abort;        // abort pulse to core
  logic [4:0] div_ff, nxt_div;            // system clock divider
  logic       tick_ff, nxt_tick;          // conversion period pulse
  logic       rc_s1_ff, rc_s2_ff, rc_s3_ff;  // rc clock synchroniser
  logic       cmp_s1_ff, cmp_s2_ff;       // comparator synchroniser
  logic       wr_acc, rd_cap;             // accepted write, read capture
  logic       wr_ctrl;                    // accepted write to control
  adcs_byte_t ctrl_rd, rd_mux;            // read views
  logic [4:0] div_last;                   // divider terminal count

  // ==========================================
  // bus slave and register file
  assign ctrl_rd = {cs_ff, 1'b0, chs_ff, go_ff, flag_ff, pwr_ff} & `ADCS_CTRL_RMASK;
  // a request waits one cycle, then waitrequest drops for one cycle
  assign wr_acc  = avs_write && !wait_ff && avs_byteenable[0];
  assign rd_cap  = avs_read && wait_ff;
  assign wr_ctrl = wr_acc && reg_hit(avs_address, `ADCS_OFF_CTRL);
  assign ev[`ADCS_IRQ_DONE]  = cif.done;
  assign ev[`ADCS_IRQ_ABORT] = abort_ff;

  always_comb begin
    rd_mux = `ADCS_RST8;  // unmapped offsets read zero
    if (reg_hit(avs_address, `ADCS_OFF_CTRL)) begin
      rd_mux = ctrl_rd;
    end else if (reg_hit(avs_address, `ADCS_OFF_RESULT)) begin
      rd_mux = res_ff;
    end else if (reg_hit(avs_address, `ADCS_OFF_PCFG)) begin
      rd_mux = pcfg_ff & `ADCS_PCFG_RMASK;
    end else if (reg_hit(avs_address, `ADCS_OFF_STAT)) begin
      rd_mux = 8'(stat_ff);
    end else if (reg_hit(avs_address, `ADCS_OFF_MASK)) begin
      rd_mux = 8'(mask_ff);
    end
  end

  // next register values; hardware events win over software writes
  always_comb begin
    nxt_wait  = !((avs_read || avs_write) && wait_ff);
    nxt_rdata = rd_cap ? {24'h0, rd_mux} : rdata_ff;
    nxt_cs    = cs_ff;
    nxt_chs   = chs_ff;
    nxt_go    = go_ff;
    nxt_flag  = flag_ff;
    nxt_pwr   = pwr_ff;
    nxt_res   = res_ff;
    nxt_pcfg  = pcfg_ff;
    nxt_mask  = mask_ff;
    nxt_start = 1'b0;
    if (wr_ctrl) begin
      nxt_cs   = avs_writedata[`ADCS_CS_HI:`ADCS_CS_LO];
      nxt_chs  = avs_writedata[`ADCS_CHS_HI:`ADCS_CHS_LO];
      nxt_pwr  = avs_writedata[`ADCS_PWR];
      nxt_flag = avs_writedata[`ADCS_FLAG];
      // a start needs power already on and a free sequencer
      nxt_go = avs_writedata[`ADCS_GO] && pwr_ff && avs_writedata[`ADCS_PWR]
               && (go_ff || cif.ready);
      nxt_start = nxt_go && !go_ff;
    end
    if (wr_acc && reg_hit(avs_address, `ADCS_OFF_RESULT)) begin
      nxt_res = avs_writedata[7:0];
    end
    if (wr_acc && reg_hit(avs_address, `ADCS_OFF_PCFG)) begin
      nxt_pcfg = avs_writedata[7:0] & `ADCS_PCFG_RMASK;
    end
    if (wr_acc && reg_hit(avs_address, `ADCS_OFF_MASK)) begin
      nxt_mask = avs_writedata[`ADCS_IRQ_W-1:0];
    end
    // clearing the start bit or powering down mid-conversion aborts
    nxt_abort = go_ff && !nxt_go && cif.busy;
    if (cif.done) begin
      nxt_res  = cif.result;
      nxt_flag = 1'b1;
      nxt_go   = 1'b0;
    end
  end

  // sticky status bits, write one to clear, set beats clear
  genvar gi;
  generate
    for (gi = 0; gi < `ADCS_IRQ_W; gi = gi + 1) begin : g_stat
      always_comb begin
        nxt_stat[gi] = stat_ff[gi];
        if (wr_acc && reg_hit(avs_address, `ADCS_OFF_STAT) && avs_writedata[gi]) begin
          nxt_stat[gi] = 1'b0;
        end
        if (ev[gi]) begin
          nxt_stat[gi] = 1'b1;
        end
      end
    end
  endgenerate
  assign nxt_irq = |(nxt_stat & nxt_mask);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wait_ff  <= 1'b1;
      rdata_ff <= 32'h0;
      cs_ff    <= `ADCS_CS_DIV2;
      chs_ff   <= 2'h0;
      go_ff    <= 1'b0;
      flag_ff  <= 1'b0;
      pwr_ff   <= 1'b0;
      res_ff   <= `ADCS_RST8;
      pcfg_ff  <= `ADCS_RST8;
      stat_ff  <= '0;
      mask_ff  <= '0;
      irq_ff   <= 1'b0;
      start_ff <= 1'b0;
      abort_ff <= 1'b0;
    end else begin
      wait_ff  <= nxt_wait;
      rdata_ff <= nxt_rdata;
      cs_ff    <= nxt_cs;
      chs_ff   <= nxt_chs;
      go_ff    <= nxt_go;
      flag_ff  <= nxt_flag;
      pwr_ff   <= nxt_pwr;
      res_ff   <= nxt_res;
      pcfg_ff  <= nxt_pcfg;
      stat_ff  <= nxt_stat;
      mask_ff  <= nxt_mask;
      irq_ff   <= nxt_irq;
      start_ff <= nxt_start;
      abort_ff <= nxt_abort;
    end
  end

  // ==========================================
  // conversion clock; divided codes stop in sleep, the rc clock does not
  always_comb begin
    case (cs_ff)
      `ADCS_CS_DIV2:  div_last = `ADCS_DIV2_LAST;
      `ADCS_CS_DIV8:  div_last = `ADCS_DIV8_LAST;
      default:        div_last = `ADCS_DIV32_LAST;
    endcase
    nxt_div  = div_ff;
    nxt_tick = 1'b0;
    if (!pwr_ff) begin
      nxt_div = 5'h0;  // no activity while unpowered
    end else if (cs_ff == `ADCS_CS_RC) begin
      nxt_tick = rc_s2_ff && !rc_s3_ff;
    end else if (!sleep_mode) begin
      if (div_ff >= div_last) begin
        nxt_div  = 5'h0;
        nxt_tick = 1'b1;
      end else begin
        nxt_div = 5'(div_ff + 5'h1);
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_ff    <= 5'h0;
      tick_ff   <= 1'b0;
      rc_s1_ff  <= 1'b0;
      rc_s2_ff  <= 1'b0;
      rc_s3_ff  <= 1'b0;
      cmp_s1_ff <= 1'b0;
      cmp_s2_ff <= 1'b0;
    end else begin
      div_ff    <= nxt_div;
      tick_ff   <= nxt_tick;
      rc_s1_ff  <= rc_clk_pin;
      rc_s2_ff  <= rc_s1_ff;
      rc_s3_ff  <= rc_s2_ff;
      cmp_s1_ff <= cmp_pin;
      cmp_s2_ff <= cmp_s1_ff;
    end
  end

  // ==========================================
  // core and outputs
  assign cif.tick  = tick_ff;
  assign cif.pwr   = pwr_ff;
  assign cif.start = start_ff;
  assign cif.abort = abort_ff;
  assign cif.cmp   = cmp_s2_ff;

  adcs_sar_core u_core (
    .clk     (clk),
    .sys_rst (sys_rst),
    .cif     (cif)
  );

  assign avs_readdata    = rdata_ff;
  assign avs_waitrequest = wait_ff;
  assign irq             = irq_ff;
  assign ana_power_en    = pwr_ff;
  assign ana_chan_sel    = chs_ff;
  assign ana_ref_ext     = pcfg_ff[`ADCS_REF_EXT];
  assign pin_analog_en   = pcfg_ff[`ADCS_ANA_HI:`ADCS_ANA_LO];
  assign sh_sample       = cif.sample;
  assign dac_code        = cif.dac;

  // ==========================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_chan;
    wr_ctrl |=> ana_chan_sel == $past(avs_writedata[`ADCS_CHS_HI:`ADCS_CHS_LO]);
  endproperty
  a_chan: assert property (p_chan) else $error("channel select not applied");
  property p_done;
    cif.done |=> res_ff == $past(cif.result) && flag_ff && !go_ff && stat_ff[`ADCS_IRQ_DONE];
  endproperty
  a_done: assert property (p_done) else $error("completion not recorded");
  property p_result_code;
    cif.done |=> dac_code == res_ff;
  endproperty
  a_result_code: assert property (p_result_code) else $error("result differs from trial");
  property p_ref;
    wr_acc && reg_hit(avs_address, `ADCS_OFF_PCFG)
      |=> ana_ref_ext == $past(avs_writedata[`ADCS_REF_EXT]);
  endproperty
  a_ref: assert property (p_ref) else $error("reference select not applied");
  property p_pins;
    wr_acc && reg_hit(avs_address, `ADCS_OFF_PCFG)
      |=> pin_analog_en == $past(avs_writedata[`ADCS_ANA_HI:`ADCS_ANA_LO]);
  endproperty
  a_pins: assert property (p_pins) else $error("pin config not applied");
  property p_sleep_rc;
    pwr_ff && sleep_mode && (cs_ff == `ADCS_CS_RC) && rc_s2_ff && !rc_s3_ff |=> tick_ff;
  endproperty
  a_sleep_rc: assert property (p_sleep_rc) else $error("rc tick lost in sleep");
  property p_div2;
    // the tick must come from the /2 count itself, not from the mode left behind
    tick_ff && pwr_ff && !sleep_mode && (cs_ff == `ADCS_CS_DIV2) && !wr_ctrl
      && ($past(cs_ff) == `ADCS_CS_DIV2)
      |=> !tick_ff ##1 tick_ff;
  endproperty
  a_div2: assert property (p_div2) else $error("div2 period wrong");
  property p_div32;
    // a /32 tick clears the count, so the next /32 tick needs 31 more steps;
    // ticks of another mode after a clock switch are not this count's
    tick_ff && ($past(cs_ff) == `ADCS_CS_DIV32)
      |=> !(tick_ff && ($past(cs_ff) == `ADCS_CS_DIV32)) [*8];
  endproperty
  a_div32: assert property (p_div32) else $error("div32 ticks too close");
  property p_no_start_off;
    wr_ctrl && !pwr_ff |=> !go_ff && !start_ff;
  endproperty
  a_no_start_off: assert property (p_no_start_off) else $error("start while off");
  property p_abort_keep;
    // a flag left set by an earlier completion is legal; only a new set is not
    abort_ff |=> ($stable(res_ff) && !$rose(flag_ff)) [*2];
  endproperty
  a_abort_keep: assert property (p_abort_keep) else $error("abort touched result");
  property p_rd_result;
    rd_cap && reg_hit(avs_address, `ADCS_OFF_RESULT) |=> avs_readdata[7:0] == $past(res_ff);
  endproperty
  a_rd_result: assert property (p_rd_result) else $error("result read wrong");
  c_done:  cover property (cif.done);
  c_abort: cover property (abort_ff);
  c_irq:   cover property (irq_ff && sleep_mode);
endmodule : adcs_top

/* verif/adcs_analog_model.sv */
// behavioural analog side: channel levels, sample-hold, comparator, rc oscillator
`timescale 1ns/1ps
module adcs_analog_model (
  input  wire logic [7:0]  dac_code,     // trial code from the sequencer
  input  wire logic [1:0]  ana_chan_sel, // routed channel
  input  wire logic        sh_sample,    // track when high, hold when low
  input  wire logic        ana_power_en, // converter powered
  input  wire logic [31:0] chan_lvls,    // four levels, channel 0 in the low byte
  output logic             cmp_pin,      // held input above trial code
  output logic             rc_clk_pin    // free-running internal rc clock
);
  logic [7:0] held_lvl;  // level on the hold capacitor
  // ==========================================
  // rc oscillator keeps running in sleep, phase unrelated to clk
  initial begin
    rc_clk_pin = 1'b0;
    forever #23 rc_clk_pin = ~rc_clk_pin;
  end
  // track the one routed channel only while sampling
  always @(sh_sample or ana_chan_sel or chan_lvls) begin
    if (sh_sample) held_lvl = chan_lvls[ana_chan_sel*8 +: 8];
  end
  // level sits half a step above its code so no trial ever ties;
  // unpowered the comparator output is junk, modelled by a toggling line
  assign cmp_pin = ana_power_en ? ({held_lvl, 1'b1} > {dac_code, 1'b0}) : rc_clk_pin;
endmodule : adcs_analog_model

/* verif/tb.sv */
// self-checking bench for the converter control sequencer
`timescale 1ns/1ps
`include "adcs_defines.svh"
module tb;
  import adcs_pkg::*;
  // ==========================================
  // stimulus and observed signals
  logic        clk, sys_rst;                 // bench clock and reset
  logic [4:0]  avs_address;                  // bus byte address
  logic        avs_read, avs_write;          // bus strobes
  logic [31:0] avs_writedata, avs_readdata;  // bus data
  logic [3:0]  avs_byteenable;               // byte lanes
  logic        avs_waitrequest, irq;         // slave answer, interrupt
  logic        sleep_mode, rc_clk_pin;       // sleep and rc clock
  logic        cmp_pin, ana_power_en;        // comparator, power
  logic [1:0]  ana_chan_sel;                 // routed channel
  logic        ana_ref_ext, sh_sample;       // reference, sample-hold
  logic [7:0]  dac_code;                     // trial code
  logic [3:0]  pin_analog_en;                // analog pin enables
  logic [31:0] chan_lvls;                    // levels seen by the model
  logic [31:0] rd;                           // last read data
  logic [7:0]  ctl;                          // control byte under test
  int          fail_count, checked;          // verdict counters
  int          n;                            // bounded wait counter
  adcs_top adcs_top_i (.clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .irq, .sleep_mode, .rc_clk_pin,
    .cmp_pin, .ana_power_en, .ana_chan_sel, .ana_ref_ext, .sh_sample, .dac_code,
    .pin_analog_en);
  adcs_analog_model adcs_analog_model_i (.dac_code, .ana_chan_sel, .sh_sample, .ana_power_en,
    .chan_lvls, .cmp_pin, .rc_clk_pin);
  // ==========================================
  // clock and watchdog; a hang counts as a mismatch
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #200000;
    fail_count++;
    end_of_test();
  end
  // ==========================================
  // helpers
  task automatic end_of_test;
    if (fail_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one bus cycle; request held until waitrequest is sampled low,
  // only the watchdog bounds the wait
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d,
                     input logic [3:0] be);
    @(posedge clk);
    avs_write <= wr;
    avs_read <= !wr;
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_byteenable <= be;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    if (!wr) chk("read upper", 32'h0, {8'h00, rd[31:8]});
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  // poll until the start bit drops, bounded
  task automatic wait_go;
    int k;
    k = 0;
    do begin
      bus(1'b0, `ADCS_OFF_CTRL, 8'h00, 4'hf);
      k++;
    end while (rd[2] !== 1'b0 && k < 400);
  endtask : wait_go
  // ==========================================
  // main sequence
  initial begin
    sys_rst = 1'b1;
    {avs_address, avs_read, avs_write, avs_writedata, sleep_mode} = '0;
    avs_byteenable = 4'hf;
    chan_lvls = 32'h5aa500ff;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    chk("irq reset", 32'h0, {31'h0, irq});
    bus(1'b0, `ADCS_OFF_CTRL, 8'h00, 4'hf); chk("ctrl reset", 32'h0, rd);
    bus(1'b0, 5'h14, 8'h00, 4'hf); chk("unmapped", 32'h0, rd);
    bus(1'b1, `ADCS_OFF_PCFG, 8'h3a, 4'hf);
    bus(1'b0, `ADCS_OFF_PCFG, 8'h00, 4'hf); chk("pcfg", 32'h1a, rd);
    chk("analog pins", 32'ha, {28'h0, pin_analog_en});
    chk("ext ref", 32'h1, {31'h0, ana_ref_ext});
    bus(1'b1, `ADCS_OFF_PCFG, 8'h0f, 4'hf);
    bus(1'b1, `ADCS_OFF_MASK, 8'h03, 4'hf);
    chk("supply ref", 32'h0, {31'h0, ana_ref_ext});
    bus(1'b1, `ADCS_OFF_CTRL, 8'h05, 4'he);
    bus(1'b0, `ADCS_OFF_CTRL, 8'h00, 4'hf); chk("lane off", 32'h0, rd);
    bus(1'b1, `ADCS_OFF_CTRL, 8'h05, 4'hf);
    bus(1'b0, `ADCS_OFF_CTRL, 8'h00, 4'hf); chk("power and go", 32'h01, rd);
    // every clock code on its own channel, the rc one while asleep
    for (int i = 0; i < 4; i++) begin
      ctl = {i[1:0], 1'b0, i[1:0], 3'b001};
      bus(1'b1, `ADCS_OFF_CTRL, ctl, 4'hf);
      sleep_mode <= (i == 3);
      bus(1'b1, `ADCS_OFF_CTRL, ctl | 8'h04, 4'hf);
      wait_go();
      chk("ctrl done", {24'h0, ctl | 8'h02}, rd);
      sleep_mode <= 1'b0;
      bus(1'b0, `ADCS_OFF_RESULT, 8'h00, 4'hf); chk("result", chan_lvls[i*8 +: 8], rd);
      chk("trial code", chan_lvls[i*8 +: 8], {24'h0, dac_code});
      chk("chan sel", i, {30'h0, ana_chan_sel});
      chk("irq done", 32'h1, {31'h0, irq});
      bus(1'b1, `ADCS_OFF_STAT, 8'h01, 4'hf);
      bus(1'b1, `ADCS_OFF_CTRL, ctl, 4'hf);
      chk("irq clear", 32'h0, {31'h0, irq});
    end
    // abort a slow conversion part way
    bus(1'b1, `ADCS_OFF_CTRL, 8'h81, 4'hf);
    bus(1'b1, `ADCS_OFF_CTRL, 8'h85, 4'hf);
    repeat (20) @(posedge clk);
    bus(1'b1, `ADCS_OFF_CTRL, 8'h81, 4'hf);
    repeat (25) @(posedge clk);
    chk("abort hold", 32'h0, {31'h0, sh_sample});
    n = 0;
    while (sh_sample !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk("reacquire", 32'h1, {31'h0, sh_sample});
    bus(1'b0, `ADCS_OFF_RESULT, 8'h00, 4'hf); chk("result kept", 32'h5a, rd);
    bus(1'b0, `ADCS_OFF_STAT, 8'h00, 4'hf); chk("abort stat", 32'h2, rd);
    chk("irq abort", 32'h1, {31'h0, irq});
    bus(1'b1, `ADCS_OFF_MASK, 8'h00, 4'hf);
    bus(1'b0, `ADCS_OFF_CTRL, 8'h00, 4'hf);
    chk("irq masked", 32'h0, {31'h0, irq});
    // unpowered converter ignores a start
    bus(1'b1, `ADCS_OFF_CTRL, 8'h00, 4'hf);
    bus(1'b1, `ADCS_OFF_CTRL, 8'h04, 4'hf);
    bus(1'b0, `ADCS_OFF_CTRL, 8'h00, 4'hf); chk("off start", 32'h0, rd);
    chk("off power", 32'h0, {31'h0, ana_power_en});
    chk("off sample", 32'h0, {31'h0, sh_sample});
    end_of_test();
  end
endmodule : tb
